/* rtl/essc_bus_cycle.v */
/*
 * One asynchronous flash bus cycle, write or read, timed in clock cycles.
 * Assumes the caller raises start for one cycle only while done is not pending.
 */
`include "essc_defs.vh"

module essc_bus_cycle (
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // Request
   input wire start,
   input wire is_read,
   input wire [22:0] bus_addr,
   input wire [15:0] wr_data,
   // Answer
   output reg done,
   output reg [15:0] rd_data,
   // Flash pins
   output reg [21:0] flash_addr,
   output reg flash_a_m1,
   output reg flash_ce_b,
   output reg flash_oe_b,
   output reg flash_we_b,
   input wire [15:0] dq_in,
   output reg [15:0] dq_out,
   output reg dq_oe
);

   localparam [31:0] ACC_CYC = `ESSC_ACCESS_CYC;
   localparam [31:0] WE_CYC = `ESSC_WE_PULSE_CYC;

   reg busy;
   reg reading;
   reg [3:0] cnt;

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         busy <= 1'b0;
         reading <= 1'b0;
         cnt <= 4'h0;
         done <= 1'b0;
         rd_data <= 16'h0000;
         flash_addr <= 22'h00_0000;
         flash_a_m1 <= 1'b0;
         flash_ce_b <= 1'b1;
         flash_oe_b <= 1'b1;
         flash_we_b <= 1'b1;
         dq_out <= 16'h0000;
         dq_oe <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            busy <= 1'b1;
            reading <= is_read;
            flash_addr <= bus_addr[22:1];
            flash_a_m1 <= bus_addr[0];
            flash_ce_b <= 1'b0;
            flash_oe_b <= !is_read;
            flash_we_b <= is_read;
            dq_out <= wr_data;
            dq_oe <= !is_read;
            cnt <= is_read ? ACC_CYC[3:0] : WE_CYC[3:0];
         end else if (busy) begin
            if (cnt > 4'h1) begin
               cnt <= cnt - 4'h1;
            end else if (!flash_ce_b) begin
               // Strobes rise first; data is held one more cycle for hold time.
               flash_ce_b <= 1'b1;
               flash_oe_b <= 1'b1;
               flash_we_b <= 1'b1;
               if (reading) begin
                  rd_data <= dq_in;
               end
            end else begin
               dq_oe <= 1'b0;
               busy <= 1'b0;
               done <= 1'b1;
            end
         end
      end
   end

endmodule

/* rtl/essc_defs.vh */
/*
 * Constants for the erase suspend, erase status check and continuity check host.
 * Assumes a 125 MHz clock and a parallel NOR flash reached through its own pins.
 */
`ifndef ESSC_DEFS_VH
`define ESSC_DEFS_VH

`define ESSC_CLK_NS 8
`define ESSC_WE_PULSE_NS 35
`define ESSC_WE_PULSE_CYC ((`ESSC_WE_PULSE_NS + `ESSC_CLK_NS - 1) / `ESSC_CLK_NS)
`define ESSC_ACCESS_NS 70
`define ESSC_ACCESS_CYC ((`ESSC_ACCESS_NS + `ESSC_CLK_NS - 1) / `ESSC_CLK_NS)
`define ESSC_SUSP_LAT_NS 20000
`define ESSC_SUSP_LAT_CYC ((`ESSC_SUSP_LAT_NS + `ESSC_CLK_NS - 1) / `ESSC_CLK_NS)
`define ESSC_RES_SUSP_NS 100000
`define ESSC_RES_SUSP_CYC ((`ESSC_RES_SUSP_NS + `ESSC_CLK_NS - 1) / `ESSC_CLK_NS)
`define ESSC_CNT_W 14

`define ESSC_OP_SUSPEND 3'h0
`define ESSC_OP_RESUME 3'h1
`define ESSC_OP_EVAL 3'h2
`define ESSC_OP_CONT 3'h3
`define ESSC_OP_SREAD 3'h4
`define ESSC_OP_SCLEAR 3'h5

`define ESSC_CODE_SUSPEND 16'h00b0
`define ESSC_CODE_RESUME 16'h0030
`define ESSC_CODE_EVAL 16'h0035
`define ESSC_CODE_SREAD 16'h0070
`define ESSC_CODE_SCLEAR 16'h0071

`define ESSC_ADDR_CMD 22'h00_0555
`define ESSC_ADDR_ANY 22'h00_0000
`define ESSC_W_PAT1_A 22'h2a_aa55
`define ESSC_W_PAT1_D 16'hff00
`define ESSC_W_PAT2_A 22'h15_55aa
`define ESSC_W_PAT2_D 16'h00ff
`define ESSC_B_PAT1_A 23'h55_54ab
`define ESSC_B_PAT1_D 16'h00ff
`define ESSC_B_PAT2_A 23'h2a_ab54
`define ESSC_B_PAT2_D 16'h0000

`define ESSC_K_WR 3'h0
`define ESSC_K_RD0 3'h1
`define ESSC_K_RD1 3'h2
`define ESSC_K_POLL 3'h3
`define ESSC_K_LAT 3'h4
`define ESSC_K_END 3'h5
`define ESSC_K_RDCAP 3'h6

`define ESSC_SR_READY 7
`define ESSC_SR_NOT_ERASED 5
`define ESSC_SR_CONT 0

`endif

/* rtl/essc_host.v */
/*
 * Host controller that issues erase suspend, erase resume, erase status evaluation,
 * status read, status clear and continuity check to a parallel NOR flash.
 * Assumes the device keeps its own command rules; one order is run at a time.
 */
`include "essc_defs.vh"

module essc_host #(
   parameter RES_SUSP_CYC = `ESSC_RES_SUSP_CYC
) (
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // User orders
   input wire cmd_valid,
   output wire cmd_ready,
   input wire [2:0] cmd_op,
   input wire [21:0] cmd_sector,
   input wire byte_mode,
   // User results
   output reg cmd_done,
   output reg cmd_fail,
   output reg [7:0] status_value,
   output reg not_erased,
   output reg suspended,
   output wire gap_busy,
   // Flash pins
   output wire [21:0] flash_addr,
   output wire flash_a_m1,
   output wire flash_ce_b,
   output wire flash_oe_b,
   output wire flash_we_b,
   input wire [15:0] dq_in,
   output wire [15:0] dq_out,
   output wire dq_oe
);

   localparam S_IDLE = 4'b0001;
   localparam S_STEP = 4'b0010;
   localparam S_BUS = 4'b0100;
   localparam S_LAT = 4'b1000;
   localparam [31:0] LAT_CYC = `ESSC_SUSP_LAT_CYC;

   reg [3:0] state;
   reg [2:0] op;
   reg [2:0] idx;
   reg [21:0] sector;
   reg bmode;
   reg [`ESSC_CNT_W-1:0] lat_cnt;
   reg [`ESSC_CNT_W-1:0] gap_cnt;
   reg bus_start;
   reg bus_read;
   reg [22:0] bus_addr;
   reg [15:0] bus_data;
   wire bus_done;
   wire [15:0] bus_rd;
   wire [41:0] cur;
   wire [2:0] cur_kind;

   // Word addresses become bus addresses with the extra low line at zero.
   function [22:0] waddr;
      input [21:0] wa;
      begin
         waddr = {wa, 1'b0};
      end
   endfunction

   // Step table: kind, bus address, data for step n of order o.
   function [41:0] step;
      input [2:0] o;
      input [2:0] n;
      input bm;
      input [21:0] sa;
      reg [41:0] wr70;
      begin
         wr70 = {`ESSC_K_WR, waddr(`ESSC_ADDR_CMD), `ESSC_CODE_SREAD};
         step = {`ESSC_K_END, 23'h00_0000, 16'h0000};
         case (o)
            `ESSC_OP_SUSPEND: begin
               if (n == 3'h0) step = {`ESSC_K_WR, waddr(`ESSC_ADDR_ANY), `ESSC_CODE_SUSPEND};
               if (n == 3'h1) step = {`ESSC_K_LAT, 23'h00_0000, 16'h0000};
            end
            `ESSC_OP_RESUME: begin
               if (n == 3'h0) step = {`ESSC_K_WR, waddr(`ESSC_ADDR_ANY), `ESSC_CODE_RESUME};
            end
            `ESSC_OP_EVAL: begin
               if (n == 3'h0) step = {`ESSC_K_WR, waddr(sa), `ESSC_CODE_EVAL};
               if (n == 3'h1) step = wr70;
               if (n == 3'h2) step = {`ESSC_K_POLL, 23'h00_0000, 16'h0000};
            end
            `ESSC_OP_CONT: begin
               // clear, check zero, pattern, check one
               case (n)
                  3'h0: step = {`ESSC_K_WR, waddr(`ESSC_ADDR_CMD), `ESSC_CODE_SCLEAR};
                  3'h1: step = wr70;
                  3'h2: step = {`ESSC_K_RD0, 23'h00_0000, 16'h0000};
                  3'h3: step = bm ? {`ESSC_K_WR, `ESSC_B_PAT1_A, `ESSC_B_PAT1_D} :
                               {`ESSC_K_WR, waddr(`ESSC_W_PAT1_A), `ESSC_W_PAT1_D};
                  3'h4: step = bm ? {`ESSC_K_WR, `ESSC_B_PAT2_A, `ESSC_B_PAT2_D} :
                               {`ESSC_K_WR, waddr(`ESSC_W_PAT2_A), `ESSC_W_PAT2_D};
                  3'h5: step = wr70;
                  3'h6: step = {`ESSC_K_RD1, 23'h00_0000, 16'h0000};
                  default: step = {`ESSC_K_END, 23'h00_0000, 16'h0000};
               endcase
            end
            `ESSC_OP_SREAD: begin
               if (n == 3'h0) step = wr70;
               if (n == 3'h1) step = {`ESSC_K_RDCAP, 23'h00_0000, 16'h0000};
            end
            `ESSC_OP_SCLEAR: begin
               if (n == 3'h0) step = {`ESSC_K_WR, waddr(`ESSC_ADDR_CMD), `ESSC_CODE_SCLEAR};
            end
            default: step = {`ESSC_K_END, 23'h00_0000, 16'h0000};
         endcase
      end
   endfunction

   assign cur = step(op, idx, bmode, sector);
   assign cur_kind = cur[41:39];
   assign gap_busy = (gap_cnt != {`ESSC_CNT_W{1'b0}});

   assign cmd_ready = (state == S_IDLE) &&
      !((cmd_op == `ESSC_OP_SUSPEND) && gap_busy) &&
      !((cmd_op == `ESSC_OP_EVAL) && suspended);

   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         state <= S_IDLE;
         op <= `ESSC_OP_SUSPEND;
         idx <= 3'h0;
         sector <= 22'h00_0000;
         bmode <= 1'b0;
         lat_cnt <= {`ESSC_CNT_W{1'b0}};
         gap_cnt <= {`ESSC_CNT_W{1'b0}};
         bus_start <= 1'b0;
         bus_read <= 1'b0;
         bus_addr <= 23'h00_0000;
         bus_data <= 16'h0000;
         cmd_done <= 1'b0;
         cmd_fail <= 1'b0;
         status_value <= 8'h00;
         not_erased <= 1'b0;
         suspended <= 1'b0;
      end else begin
         cmd_done <= 1'b0;
         bus_start <= 1'b0;
         if (gap_busy) begin
            gap_cnt <= gap_cnt - {{(`ESSC_CNT_W-1){1'b0}}, 1'b1};
         end
         case (state)
            S_IDLE: begin
               if (cmd_valid && cmd_ready) begin
                  op <= cmd_op;
                  sector <= cmd_sector;
                  bmode <= byte_mode;
                  idx <= 3'h0;
                  cmd_fail <= 1'b0;
                  state <= S_STEP;
               end
            end
            S_STEP: begin
               case (cur_kind)
                  `ESSC_K_END: begin
                     cmd_done <= 1'b1;
                     state <= S_IDLE;
                     if (op == `ESSC_OP_SUSPEND) begin
                        suspended <= 1'b1;
                     end
                     if (op == `ESSC_OP_RESUME) begin
                        suspended <= 1'b0;
                        gap_cnt <= RES_SUSP_CYC[`ESSC_CNT_W-1:0];
                     end
                  end
                  `ESSC_K_LAT: begin
                     lat_cnt <= LAT_CYC[`ESSC_CNT_W-1:0];
                     state <= S_LAT;
                  end
                  default: begin
                     bus_start <= 1'b1;
                     bus_read <= (cur_kind != `ESSC_K_WR);
                     bus_addr <= cur[38:16];
                     bus_data <= cur[15:0];
                     state <= S_BUS;
                  end
               endcase
            end
            S_BUS: begin
               if (bus_done) begin
                  state <= S_STEP;
                  idx <= idx + 3'h1;
                  if (cur_kind != `ESSC_K_WR) begin
                     status_value <= bus_rd[7:0];
                  end
                  // status bit 0 clear then set
                  if (cur_kind == `ESSC_K_RD0 && bus_rd[`ESSC_SR_CONT]) begin
                     cmd_fail <= 1'b1;
                  end
                  if (cur_kind == `ESSC_K_RD1 && !bus_rd[`ESSC_SR_CONT]) begin
                     cmd_fail <= 1'b1;
                  end
                  if (cur_kind == `ESSC_K_POLL) begin
                     // poll ready bit, then erased bit
                     if (!bus_rd[`ESSC_SR_READY]) begin
                        idx <= idx - 3'h1;
                     end else begin
                        not_erased <= bus_rd[`ESSC_SR_NOT_ERASED];
                        cmd_fail <= bus_rd[`ESSC_SR_NOT_ERASED];
                     end
                  end
               end
            end
            S_LAT: begin
               if (lat_cnt > {{(`ESSC_CNT_W-1){1'b0}}, 1'b1}) begin
                  lat_cnt <= lat_cnt - {{(`ESSC_CNT_W-1){1'b0}}, 1'b1};
               end else begin
                  idx <= idx + 3'h1;
                  state <= S_STEP;
               end
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   essc_bus_cycle u_bus (
      .clock(clock),
      .rst_b(rst_b),
      .start(bus_start),
      .is_read(bus_read),
      .bus_addr(bus_addr),
      .wr_data(bus_data),
      .done(bus_done),
      .rd_data(bus_rd),
      .flash_addr(flash_addr),
      .flash_a_m1(flash_a_m1),
      .flash_ce_b(flash_ce_b),
      .flash_oe_b(flash_oe_b),
      .flash_we_b(flash_we_b),
      .dq_in(dq_in),
      .dq_out(dq_out),
      .dq_oe(dq_oe)
   );

endmodule

/* tb/essc_flash_model.sv */
/* Behavioural flash: suspend and resume, erase status check, continuity, status.
   Assumes the host holds strobes over whole clock cycles; states 0 standby,
   1 erase time-out, 2 erasing, 3 suspended, 4 chip erase, 5 evaluating, 6 suspending. */
`include "essc_defs.vh"
module essc_flash_model #(parameter LAT = 40, parameter EVAL = 30) (
   // Test control
   input wire logic clock,
   input wire logic rst_b,
   input wire logic go_erase,
   input wire logic [2:0] go_kind,
   input wire logic [21:0] bad_sector,
   output logic [2:0] m_state,
   // Flash pins
   input wire logic [21:0] flash_addr,
   input wire logic flash_a_m1,
   input wire logic flash_ce_b,
   input wire logic flash_oe_b,
   input wire logic flash_we_b,
   input wire logic [15:0] dq_out,
   output logic [15:0] dq_in
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] sr;
   logic [22:0] a;
   logic [15:0] d;
   logic [15:0] last;
   logic we_q;
   logic p1;
   logic sread;
   int cnt;
   wire rd = !flash_ce_b && !flash_oe_b;
   // ready bit reads low while the sector erase runs, high once suspended.
   wire erasing = m_state == 3'h1 || m_state == 3'h2 || m_state == 3'h6;
   // status after 70, otherwise array; released bus shows the inverse.
   assign dq_in = rd ? (sread ? {8'h00, sr[7] && !erasing, sr[6:0]} : 16'h5aa5) : ~last;
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         m_state <= 3'h0;
         sr <= 8'h80;
         we_q <= 1'b1;
         {p1, sread, cnt, last} <= '0;
      end else begin
         we_q <= flash_we_b;
         if (rd) last <= dq_in;
         if (!flash_we_b) {a, d} <= {flash_addr, flash_a_m1, dq_out};
         if (cnt > 0) cnt <= cnt - 1;
         if (cnt == 1 && m_state == 3'h6) m_state <= 3'h3;
         // evaluation ends ready, back to standby.
         if (cnt == 1 && m_state == 3'h5) {m_state, sr[7]} <= 4'h1;
         if (go_erase) m_state <= go_kind;
         if (flash_we_b && !we_q) begin
            sread <= d[7:0] == 8'h70;
            // pattern pair sets bit zero, clear resets it.
            p1 <= a == {`ESSC_W_PAT1_A, 1'b0} && d == `ESSC_W_PAT1_D
               || a == `ESSC_B_PAT1_A && d[7:0] == 8'hff;
            if (p1 && (a == {`ESSC_W_PAT2_A, 1'b0} && d == `ESSC_W_PAT2_D
               || a == `ESSC_B_PAT2_A && d[7:0] == 8'h00)) sr[0] <= 1'b1;
            if (d[7:0] == 8'h71) sr[0] <= 1'b0;
            // suspend only in sector erase; time-out ends at once.
            if (d[7:0] == 8'hb0 && m_state == 3'h1) m_state <= 3'h3;
            if (d[7:0] == 8'hb0 && m_state == 3'h2) {m_state, cnt} <= {3'h6, LAT};
            // resume only from suspended, address ignored.
            if (d[7:0] == 8'h30 && m_state == 3'h3) m_state <= 3'h2;
            // evaluate from standby only, early stop when not erased.
            if (d[7:0] == 8'h35 && m_state == 3'h0) begin
               {m_state, sr[7], sr[5]} <= {3'h5, 1'b0, a[22:1] == bad_sector};
               cnt <= a[22:1] == bad_sector ? EVAL / 2 : EVAL;
            end
         end
      end
   end
endmodule

/* tb/essc_host_monitor.sv */
/* Checker on the essc_host ports: order gating, strobes, suspend and results.
   Assumes it is bound to every essc_host instance. */
`include "essc_defs.vh"
module essc_host_monitor #(parameter RES_SUSP_CYC = 20) (
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // User side
   input wire cmd_valid,
   input wire cmd_ready,
   input wire [2:0] cmd_op,
   input wire cmd_done,
   input wire cmd_fail,
   input wire [7:0] status_value,
   input wire not_erased,
   input wire suspended,
   input wire gap_busy,
   // Flash strobes
   input wire flash_ce_b,
   input wire flash_oe_b,
   input wire flash_we_b,
   input wire dq_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   reg [2:0] op_q;
   int wait_n;
   int gap_n;
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         op_q <= 3'h0;
         wait_n <= 0;
         gap_n <= 0;
      end else begin
         gap_n <= gap_busy ? gap_n + 1 : 0;
         if (cmd_valid && cmd_ready) begin
            op_q <= cmd_op;
            wait_n <= 0;
         end else begin
            wait_n <= wait_n + 1;
         end
      end
   end
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_b);
   a_susp_latency: assert property (cmd_done && op_q == `ESSC_OP_SUSPEND |->
      wait_n >= `ESSC_SUSP_LAT_CYC)
      else $error("suspend finished before latency");
   a_susp_sets: assert property ($rose(suspended) |-> op_q == `ESSC_OP_SUSPEND)
      else $error("suspended rose without suspend");
   a_resume_clears: assert property ($fell(suspended) |-> op_q == `ESSC_OP_RESUME)
      else $error("suspended fell without resume");
   a_gap_blocks: assert property (gap_busy && cmd_op == `ESSC_OP_SUSPEND |-> !cmd_ready)
      else $error("suspend accepted inside gap");
   a_gap_length: assert property ($fell(gap_busy) |-> gap_n >= RES_SUSP_CYC - 1)
      else $error("gap too short");
   a_eval_blocks: assert property (suspended && cmd_op == `ESSC_OP_EVAL |-> !cmd_ready)
      else $error("evaluate accepted while suspended");
   a_we_width: assert property ($fell(flash_we_b) |-> !flash_we_b [*5] ##1 flash_we_b)
      else $error("write strobe width wrong");
   a_write_drive: assert property (!flash_we_b |-> dq_oe && !flash_ce_b && flash_oe_b)
      else $error("write cycle without data drive");
   a_read_width: assert property ($fell(flash_oe_b) |-> !dq_oe ##0 !flash_oe_b [*8])
      else $error("read strobe short or bus driven");
   a_eval_result: assert property (cmd_done && op_q == `ESSC_OP_EVAL |->
      status_value[7] && cmd_fail == not_erased && not_erased == status_value[5])
      else $error("evaluate result mismatch");
   a_cont_result: assert property (cmd_done && op_q == `ESSC_OP_CONT && !cmd_fail |->
      status_value[0])
      else $error("continuity pass without bit zero");
endmodule
bind essc_host essc_host_monitor #(.RES_SUSP_CYC(RES_SUSP_CYC)) u_mon (.clock, .rst_b,
   .cmd_valid, .cmd_ready, .cmd_op, .cmd_done, .cmd_fail, .status_value, .not_erased,
   .suspended, .gap_busy, .flash_ce_b, .flash_oe_b, .flash_we_b, .dq_oe);

/* tb/essc_host_tb_top.sv */
/* Bench for essc_host: order tasks with expected results against a flash model.
   Assumes essc_flash_model and the bound checker are compiled alongside. */
`include "essc_defs.vh"
module essc_host_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, byte_mode = 1'b0, go_erase = 1'b0;
   logic [2:0] cmd_op = 3'h0, go_kind = 3'h0, m_state;
   logic [21:0] cmd_sector = 22'h00_0000, bad_sector = 22'h00_8000;
   wire cmd_ready, cmd_done, cmd_fail, not_erased, suspended, gap_busy, flash_a_m1;
   wire flash_ce_b, flash_oe_b, flash_we_b, dq_oe;
   wire [7:0] status_value;
   wire [21:0] flash_addr;
   wire [15:0] dq_in, dq_out;
   int failures = 0, total_checks = 0, cycles = 0;
   always #4 clock = ~clock;
   essc_host #(.RES_SUSP_CYC(20)) dut (.clock, .rst_b, .cmd_valid, .cmd_ready, .cmd_op,
      .cmd_sector, .byte_mode, .cmd_done, .cmd_fail, .status_value, .not_erased, .suspended,
      .gap_busy, .flash_addr, .flash_a_m1, .flash_ce_b, .flash_oe_b, .flash_we_b, .dq_in,
      .dq_out, .dq_oe);
   essc_flash_model model (.clock, .rst_b, .go_erase, .go_kind, .bad_sector, .m_state,
      .flash_addr, .flash_a_m1, .flash_ce_b, .flash_oe_b, .flash_we_b, .dq_out, .dq_in);
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic order(input logic [2:0] op, input logic [21:0] sec, input logic bm);
      @(negedge clock);
      {cmd_op, cmd_sector, byte_mode, cmd_valid} = {op, sec, bm, 1'b1};
      do @(posedge clock); while (cmd_ready !== 1'b1);
      @(negedge clock) cmd_valid = 1'b0;
      while (cmd_done !== 1'b1) @(negedge clock);
   endtask
   task automatic erase(input logic [2:0] kind);
      @(negedge clock) {go_kind, go_erase} = {kind, 1'b1};
      @(negedge clock) go_erase = 1'b0;
   endtask
   task automatic end_sim();
      $display("checks=%0d failures=%0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      repeat (12) @(posedge clock);
      @(negedge clock) rst_b = 1'b1;
      for (int i = 0; i < 3; i++) begin
         order(`ESSC_OP_CONT, 22'h00_0000, i[0]);
         chk(cmd_fail, 1'b0);
         chk(status_value[0], 1'b1);
      end
      order(`ESSC_OP_SCLEAR, 22'h00_0000, 1'b0);
      order(`ESSC_OP_SREAD, 22'h00_0000, 1'b0);
      chk(status_value, 8'h80);
      $display("test continuity and status done");
      order(`ESSC_OP_EVAL, 22'h00_4000, 1'b0);
      chk({cmd_fail, not_erased, status_value[7]}, 3'h1);
      order(`ESSC_OP_EVAL, bad_sector, 1'b0);
      chk({cmd_fail, not_erased, status_value[7]}, 3'h7);
      chk(m_state, 3'h0);
      $display("test evaluate done");
      erase(3'h1);
      order(`ESSC_OP_SUSPEND, 22'h00_0000, 1'b0);
      chk({suspended, m_state}, 4'hb);
      order(`ESSC_OP_SREAD, 22'h00_0000, 1'b0);
      chk(status_value[7], 1'b1);
      @(negedge clock) cmd_op = `ESSC_OP_EVAL;
      #1 chk(cmd_ready, 1'b0);
      order(`ESSC_OP_RESUME, 22'h00_0000, 1'b0);
      chk({suspended, m_state}, 4'h2);
      order(`ESSC_OP_RESUME, 22'h00_0000, 1'b0);
      chk(m_state, 3'h2);
      @(negedge clock) cmd_op = `ESSC_OP_SUSPEND;
      #1 chk({gap_busy, cmd_ready}, 2'h2);
      order(`ESSC_OP_SUSPEND, 22'h00_0000, 1'b0);
      chk({suspended, m_state}, 4'hb);
      order(`ESSC_OP_RESUME, 22'h00_0000, 1'b0);
      order(`ESSC_OP_SREAD, 22'h00_0000, 1'b0);
      chk(status_value[7], 1'b0);
      $display("test suspend and resume done");
      erase(3'h4);
      order(`ESSC_OP_SUSPEND, 22'h00_0000, 1'b0);
      chk(m_state, 3'h4);
      order(`ESSC_OP_RESUME, 22'h00_0000, 1'b0);
      order(`ESSC_OP_EVAL, 22'h00_4000, 1'b0);
      chk({m_state, not_erased}, 4'h9);
      $display("test ignored commands done");
      end_sim();
   end
endmodule
